/* sccr_top.sv */
// System clock select, switchback, lockout, status and reset control with AXI4-Lite registers
`timescale 1ns/10ps
`include "sccr_map.svh"

// Operation
// - Two-bit select picks raw source, source/256, or multiplied source as system clock.
// - Machine cycle is system clock divided by four; peripherals use system clock.
// - Multiplier enabled only with enable bit set and select equal to 00.
// - Factor bit zero multiplies by two, one multiplies by four.
// - Select 11 is slow mode: source/256, machine cycle 1024 source clocks.
// - New clock rate takes effect one machine cycle after the control write.
// - Select changes must pass through 10; other direct changes are ignored.
// - Multiplier engage order enforced; out-of-order select writes leave the select unchanged.
// - Multiplier ready sets after 65,536 source cycles of multiplier enable.
// - Multiplier engages the machine cycle after select written to 00.
// - In slow mode with switchback on, acknowledged external interrupt returns to divide-by-four.
// - No interrupt switchback if interrupt disabled or higher priority level in service.
// - In slow mode with switchback on, enabled port start bit or buffer load returns.
// - Three status bits show power-fail, high and low levels in service.
// - Select writes ignored while any serial port transmits or receives.
// - Per-port serial transmit and receive activity shown in the two status registers.
// - With detection enabled, oscillator below about 100 kHz holds the device in reset.
// - Oscillator-fail enable writable only through the timed-access procedure.
// - Oscillator fail sets the fail flag; cleared by power-fail reset or software zero.
// - Oscillator stopped by stop mode never triggers an oscillator-fail reset.
// - Reset held while supply low; then 65,536 clocks before execution from zero.
// - Power-on reset flag set after power-on reset; software reads and clears it.
// - Ring-oscillator-active flag clears after 65,536 external source cycles.
module sccr_top
    import sccr_pkg::*;
#(
    parameter int LOCK_CYCLES = `SCCR_LOCK_CYCLES
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire sccr_serial_t serial,
    input wire sccr_irq_t irq,
    input wire logic supply_ok,
    input wire logic osc_fail_det,
    input wire logic stop_mode,
    input wire logic ring_osc_exit,
    output logic sys_clk_en,
    output logic mcycle_en,
    output logic mult_active,
    output logic mult_x4_active,
    output logic slow_clock_mode,
    output logic cpu_reset_n,
    output logic [15:0] cpu_start_addr
);

    logic [1:0] cd_r, cd_act_r, ta_stage_r, bresp_r, rresp_r, cd_req;
    logic x4_act_r, switchback_enable_r, multiplier_enable_r, multiplier_factor_r, multiplier_ready_r;
    logic ring_osc_active_r, osc_fail_detect_enable_r, osc_fail_flag_r, por_flag_r, bvalid_r, rvalid_r;
    logic [16:0] lock_cnt_r, ring_cnt_r;
    logic [4:0] ta_cnt_r;
    logic [31:0] rdata_r;
    logic [7:0] wr_idx, rd_idx, wbyte;
    logic wr_go, rd_go, wr_pm, serial_busy, sb_irq, sb_serial, switchback, cd_ok;
    logic sys_tick, mc_tick, core_rst_n, pwr_fail_evt, pwr_up_evt, ofd_evt;

    // Register index from a byte address
    function automatic logic [7:0] reg_idx(input logic [9:0] addr);
        return addr[9:2];
    endfunction

    // Index is one of the mapped registers
    function automatic logic idx_mapped(input logic [7:0] idx);
        return idx == `SCCR_IDX_PMGMT || idx == `SCCR_IDX_EXTFLAGS || idx == `SCCR_IDX_PCTRL ||
               idx == `SCCR_IDX_TACCESS || idx == `SCCR_IDX_WDCTRL || idx == `SCCR_IDX_STATUS ||
               idx == `SCCR_IDX_SERIAL_ACTIVITY_STATUS_EXT;
    endfunction

    // Bus write path: address and data taken together, one write outstanding
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign wr_idx = reg_idx(s_axi_awaddr);
    assign wbyte = s_axi_wdata[7:0];

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= `SCCR_RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= idx_mapped(wr_idx) ? `SCCR_RESP_OKAY : `SCCR_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_r <= 1'b0;
    end

    // Bus read path: data registered one cycle after address taken
    assign rd_go = s_axi_arvalid && !rvalid_r;
    assign s_axi_arready = rd_go;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign rd_idx = reg_idx(s_axi_araddr);

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `SCCR_RESP_OKAY;
        end
        else if (rd_go)
        begin
            rvalid_r <= 1'b1;
            rresp_r <= idx_mapped(rd_idx) ? `SCCR_RESP_OKAY : `SCCR_RESP_SLVERR;
            rdata_r <= 32'h00000000;
            unique case (rd_idx)
                `SCCR_IDX_PMGMT:
                    rdata_r[7:3] <= {cd_r, switchback_enable_r, multiplier_enable_r, multiplier_factor_r};
                `SCCR_IDX_EXTFLAGS:
                    rdata_r[3:2] <= {multiplier_ready_r, ring_osc_active_r};
                `SCCR_IDX_PCTRL:
                    rdata_r[5:4] <= {osc_fail_flag_r, osc_fail_detect_enable_r};
                `SCCR_IDX_WDCTRL:
                    rdata_r[`SCCR_WD_POR] <= por_flag_r;
                `SCCR_IDX_STATUS:
                    rdata_r[7:0] <= {irq.powerfail_level_in_service, irq.high_level_in_service,
                                     irq.low_level_in_service, 1'b0,
                                     serial.rx_active[1], serial.tx_active[1],
                                     serial.rx_active[0], serial.tx_active[0]};
                `SCCR_IDX_SERIAL_ACTIVITY_STATUS_EXT:
                    rdata_r[1:0] <= {serial.rx_active[2], serial.tx_active[2]};
                default:
                    rdata_r <= 32'h00000000;
            endcase
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    // Switchback sources
    assign serial_busy = |(serial.tx_active | serial.rx_active);
    assign sb_irq = irq.ext_int_ack && irq.ext_int_enabled && !irq.powerfail_level_in_service &&
                    (irq.ext_int_high_prio || !irq.high_level_in_service);
    assign sb_serial = |(serial.enabled & (serial.start_bit | serial.buf_load));
    assign switchback = switchback_enable_r && cd_r == `SCCR_CD_SLOW && (sb_irq || sb_serial);

    // Divide-select write legality
    assign wr_pm = wr_go && wr_idx == `SCCR_IDX_PMGMT && s_axi_wstrb[0];
    assign cd_req = wbyte[`SCCR_PM_CD_HI:`SCCR_PM_CD_LO];

    always_comb
    begin
        cd_ok = 1'b0;
        if (cd_req == cd_r)
            cd_ok = 1'b1;
        else if (cd_req == `SCCR_CD_DIV4)
            cd_ok = cd_r == `SCCR_CD_MULT || cd_r == `SCCR_CD_SLOW;
        else if (cd_r == `SCCR_CD_DIV4 && cd_req == `SCCR_CD_SLOW)
            cd_ok = 1'b1;
        else if (cd_r == `SCCR_CD_DIV4 && cd_req == `SCCR_CD_MULT)
            cd_ok = multiplier_enable_r && multiplier_ready_r && !ring_osc_active_r;
    end

    // Clock control bits
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cd_r <= `SCCR_CD_RESET;
            switchback_enable_r <= 1'b0;
            multiplier_enable_r <= 1'b0;
            multiplier_factor_r <= 1'b0;
        end
        else
        begin
            if (switchback)
                cd_r <= `SCCR_CD_DIV4;
            else if (wr_pm && cd_ok && !serial_busy)
                cd_r <= cd_req;
            if (wr_pm)
            begin
                switchback_enable_r <= wbyte[`SCCR_PM_SWB];
                if (cd_r != `SCCR_CD_MULT)
                    multiplier_enable_r <= wbyte[`SCCR_PM_MEN];
                if (!multiplier_enable_r)
                    multiplier_factor_r <= wbyte[`SCCR_PM_MFAC];
            end
        end
    end

    // Applied clock selection follows the control bits at the next machine cycle boundary
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cd_act_r <= `SCCR_CD_RESET;
            x4_act_r <= 1'b0;
        end
        else if (mc_tick)
        begin
            cd_act_r <= cd_r;
            x4_act_r <= multiplier_factor_r;
        end
    end

    // Multiplier lock counter and ready flag
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            lock_cnt_r <= 17'h00000;
            multiplier_ready_r <= 1'b0;
        end
        else if (!multiplier_enable_r)
        begin
            lock_cnt_r <= 17'h00000;
            multiplier_ready_r <= 1'b0;
        end
        else if (!multiplier_ready_r)
        begin
            lock_cnt_r <= lock_cnt_r + 17'h00001;
            if (lock_cnt_r == 17'(LOCK_CYCLES - 1))
            begin
                multiplier_ready_r <= 1'b1;
            end
        end
    end

    // Ring oscillator flag, cleared after the external source has run long enough
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ring_cnt_r <= 17'h00000;
            ring_osc_active_r <= 1'b0;
        end
        else if (ring_osc_exit)
        begin
            ring_cnt_r <= 17'h00000;
            ring_osc_active_r <= 1'b1;
        end
        else if (ring_osc_active_r)
        begin
            ring_cnt_r <= ring_cnt_r + 17'h00001;
            if (ring_cnt_r == 17'(LOCK_CYCLES - 1))
            begin
                ring_osc_active_r <= 1'b0;
            end
        end
    end

    // Timed access: key pair opens a short window for the protected enable bit
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ta_stage_r <= 2'h0;
            ta_cnt_r <= 5'h00;
        end
        else if (wr_go && wr_idx == `SCCR_IDX_TACCESS && s_axi_wstrb[0])
        begin
            ta_cnt_r <= `SCCR_TA_WINDOW;
            if (wbyte == `SCCR_TA_KEY1)
                ta_stage_r <= 2'h1;
            else if (wbyte == `SCCR_TA_KEY2 && ta_stage_r == 2'h1 && ta_cnt_r != 5'h00)
                ta_stage_r <= 2'h2;
            else
                ta_stage_r <= 2'h0;
        end
        else if (wr_go && wr_idx == `SCCR_IDX_PCTRL)
            ta_stage_r <= 2'h0;
        else if (ta_cnt_r != 5'h00)
            ta_cnt_r <= ta_cnt_r - 5'h01;
        else
            ta_stage_r <= 2'h0;
    end

    // Oscillator-fail enable and flag, power-on flag
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            osc_fail_detect_enable_r <= 1'b0;
            osc_fail_flag_r <= 1'b0;
            por_flag_r <= 1'b1;
        end
        else
        begin
            if (wr_go && wr_idx == `SCCR_IDX_PCTRL && s_axi_wstrb[0] && ta_stage_r == 2'h2)
                osc_fail_detect_enable_r <= wbyte[`SCCR_PC_OSC_FAIL_DETECT_ENABLE];
            if (ofd_evt)
                osc_fail_flag_r <= 1'b1;
            else if (pwr_fail_evt)
                osc_fail_flag_r <= 1'b0;
            else if (wr_go && wr_idx == `SCCR_IDX_PCTRL && s_axi_wstrb[0] && !wbyte[`SCCR_PC_OSC_FAIL_FLAG])
                osc_fail_flag_r <= 1'b0;
            if (pwr_up_evt)
                por_flag_r <= 1'b1;
            else if (wr_go && wr_idx == `SCCR_IDX_WDCTRL && s_axi_wstrb[0] && !wbyte[`SCCR_WD_POR])
                por_flag_r <= 1'b0;
        end
    end

    sccr_clkdiv u_clkdiv (
        .clk(clk),
        .rstn(rstn),
        .cd(cd_act_r),
        .mult_x4(x4_act_r),
        .sys_tick(sys_tick),
        .mc_tick(mc_tick)
    );

    sccr_rstseq #(
        .LOCK_CYCLES(LOCK_CYCLES)
    ) u_rstseq (
        .clk(clk),
        .rstn(rstn),
        .supply_ok(supply_ok),
        .osc_fail_det(osc_fail_det),
        .ofd_enable(osc_fail_detect_enable_r),
        .stop_mode(stop_mode),
        .core_rst_n(core_rst_n),
        .pwr_fail_evt(pwr_fail_evt),
        .pwr_up_evt(pwr_up_evt),
        .ofd_evt(ofd_evt)
    );

    // Clock, reset and start address outputs
    assign sys_clk_en = sys_tick;
    assign mcycle_en = mc_tick;
    assign mult_active = multiplier_enable_r && cd_act_r == `SCCR_CD_MULT;
    assign mult_x4_active = mult_active && x4_act_r;
    assign slow_clock_mode = cd_act_r == `SCCR_CD_SLOW;
    assign cpu_reset_n = core_rst_n;
    assign cpu_start_addr = `SCCR_RESET_VECTOR;

endmodule // sccr_top

/* sccr_map.svh */
// Register map, field positions, reset values and timing counts of the clock and reset control
`ifndef SCCR_MAP_SVH
`define SCCR_MAP_SVH

`define SCCR_CLK_HZ 20000000
`define SCCR_LOCK_CYCLES 65536
`define SCCR_TA_WINDOW 5'h10
`define SCCR_TA_KEY1 8'hAA
`define SCCR_TA_KEY2 8'h55
`define SCCR_IDX_PMGMT 8'h01
`define SCCR_IDX_EXTFLAGS 8'h02
`define SCCR_IDX_PCTRL 8'h03
`define SCCR_IDX_TACCESS 8'h04
`define SCCR_IDX_WDCTRL 8'h05
`define SCCR_IDX_STATUS 8'hC5
`define SCCR_IDX_SERIAL_ACTIVITY_STATUS_EXT 8'hF7
`define SCCR_PM_CD_HI 7
`define SCCR_PM_CD_LO 6
`define SCCR_PM_SWB 5
`define SCCR_PM_MEN 4
`define SCCR_PM_MFAC 3
`define SCCR_EX_MRDY 3
`define SCCR_EX_RING 2
`define SCCR_PC_OSC_FAIL_FLAG 5
`define SCCR_PC_OSC_FAIL_DETECT_ENABLE 4
`define SCCR_WD_POR 6
`define SCCR_CD_MULT 2'h0
`define SCCR_CD_DIV4 2'h2
`define SCCR_CD_SLOW 2'h3
`define SCCR_CD_RESET 2'h2
`define SCCR_MC_DIV4 10'h003
`define SCCR_MC_SLOW 10'h3FF
`define SCCR_MC_X2 10'h001
`define SCCR_MC_X4 10'h000
`define SCCR_SLOW_SYS_MASK 10'h0FF
`define SCCR_RESET_VECTOR 16'h0000
`define SCCR_RESP_OKAY 2'h0
`define SCCR_RESP_SLVERR 2'h2

`endif

/* sccr_pkg.sv */
// Types shared by the clock and reset control
package sccr_pkg;

    typedef struct packed {
        logic [2:0] enabled;
        logic [2:0] tx_active;
        logic [2:0] rx_active;
        logic [2:0] start_bit;
        logic [2:0] buf_load;
    } sccr_serial_t;

    typedef struct packed {
        logic powerfail_level_in_service;
        logic high_level_in_service;
        logic low_level_in_service;
        logic ext_int_ack;
        logic ext_int_enabled;
        logic ext_int_high_prio;
    } sccr_irq_t;

    typedef enum logic [1:0] {
        SCCR_RST_HOLD,
        SCCR_RST_COUNT,
        SCCR_RST_RUN
    } sccr_rst_state_t;

endpackage

/* sccr_clkdiv.sv */
// Oscillator tick divider producing system clock and machine cycle enables
`timescale 1ns/10ps
`include "sccr_map.svh"

module sccr_clkdiv
    import sccr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] cd,
    input wire logic mult_x4,
    output logic sys_tick,
    output logic mc_tick
);

    logic [9:0] cnt_r;
    logic [9:0] last;

    // Oscillator clocks per machine cycle, less one
    function automatic logic [9:0] mc_last(input logic [1:0] sel, input logic x4);
        logic [9:0] v;
        v = `SCCR_MC_DIV4;
        if (sel == `SCCR_CD_SLOW)
        begin
            v = `SCCR_MC_SLOW;
        end
        else if (sel == `SCCR_CD_MULT)
        begin
            v = x4 ? `SCCR_MC_X4 : `SCCR_MC_X2;
        end
        return v;
    endfunction

    assign last = mc_last(cd, mult_x4);

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cnt_r <= 10'h000;
        end
        else if (cnt_r >= last)
        begin
            cnt_r <= 10'h000;
        end
        else
        begin
            cnt_r <= cnt_r + 10'h001;
        end
    end

    // Slow mode: system clock is source/256, machine cycle four of those
    always_comb
    begin
        if (cd == `SCCR_CD_SLOW)
        begin
            sys_tick = (cnt_r & `SCCR_SLOW_SYS_MASK) == `SCCR_SLOW_SYS_MASK;
        end
        else
        begin
            sys_tick = 1'b1;
        end
    end

    assign mc_tick = cnt_r >= last;

endmodule // sccr_clkdiv

/* sccr_rstseq.sv */
// Power-on, power-fail and oscillator-fail reset sequencer
`timescale 1ns/10ps
`include "sccr_map.svh"

module sccr_rstseq
    import sccr_pkg::*;
#(
    parameter int LOCK_CYCLES = `SCCR_LOCK_CYCLES
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic supply_ok,
    input wire logic osc_fail_det,
    input wire logic ofd_enable,
    input wire logic stop_mode,
    output logic core_rst_n,
    output logic pwr_fail_evt,
    output logic pwr_up_evt,
    output logic ofd_evt
);

    logic sup_s1_r;
    logic sup_s2_r;
    logic sup_d_r;
    logic osc_s1_r;
    logic osc_s2_r;
    logic ofd_d_r;
    logic fail;
    logic ofd;
    logic [16:0] cnt_r;
    sccr_rst_state_t state_r;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sup_s1_r <= 1'b0;
            sup_s2_r <= 1'b0;
            sup_d_r <= 1'b0;
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            ofd_d_r <= 1'b0;
        end
        else
        begin
            sup_s1_r <= supply_ok;
            sup_s2_r <= sup_s1_r;
            sup_d_r <= sup_s2_r;
            osc_s1_r <= osc_fail_det;
            osc_s2_r <= osc_s1_r;
            ofd_d_r <= ofd;
        end
    end

    assign fail = !sup_s2_r;
    assign ofd = ofd_enable && osc_s2_r && !stop_mode;

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            state_r <= SCCR_RST_HOLD;
            cnt_r <= 17'h00000;
        end
        else
        begin
            unique case (state_r)
                SCCR_RST_HOLD:
                begin
                    cnt_r <= 17'h00000;
                    if (!fail && !ofd)
                    begin
                        state_r <= SCCR_RST_COUNT;
                    end
                end
                SCCR_RST_COUNT:
                begin
                    cnt_r <= cnt_r + 17'h00001;
                    if (fail || ofd)
                    begin
                        state_r <= SCCR_RST_HOLD;
                    end
                    else if (cnt_r == 17'(LOCK_CYCLES - 1))
                    begin
                        state_r <= SCCR_RST_RUN;
                    end
                end
                SCCR_RST_RUN:
                begin
                    if (fail || ofd)
                    begin
                        state_r <= SCCR_RST_HOLD;
                    end
                end
            endcase
        end
    end

    assign core_rst_n = state_r == SCCR_RST_RUN;
    assign pwr_fail_evt = sup_d_r && !sup_s2_r;
    assign pwr_up_evt = !sup_d_r && sup_s2_r;
    assign ofd_evt = ofd && !ofd_d_r;

endmodule // sccr_rstseq

/* sccr_monitor.sv */
// Port checker for the clock and reset control
`timescale 1ns/10ps
module sccr_monitor
    import sccr_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic sys_clk_en,
    input wire logic mcycle_en,
    input wire logic mult_active,
    input wire logic mult_x4_active,
    input wire logic slow_clock_mode,
    input wire logic [15:0] cpu_start_addr
);
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    AST_DIV4_GAP:
        assert property (mcycle_en && !mult_active && !slow_clock_mode ##1 !mult_active && !slow_clock_mode
            |-> !mcycle_en [*3]) else $error("machine cycle gap wrong");
    AST_X4_EVERY:
        assert property (mult_active && mult_x4_active |-> mcycle_en && sys_clk_en) else $error("x4 cycle missing");
    AST_X2_ALT:
        assert property (mult_active && !mult_x4_active && mcycle_en ##1 mult_active && !mult_x4_active
            |-> !mcycle_en) else $error("x2 cycle too fast");
    AST_SLOW_SYS:
        assert property (slow_clock_mode && sys_clk_en ##1 slow_clock_mode |-> !sys_clk_en [*8])
            else $error("slow system tick too fast");
    AST_FAST_SYS:
        assert property (!slow_clock_mode |-> sys_clk_en) else $error("system tick missing");
    AST_MODE_AT_MC:
        assert property ($changed(slow_clock_mode) || $changed(mult_active) |-> $past(mcycle_en))
            else $error("mode changed off machine cycle");
    AST_START_ZERO:
        assert property (cpu_start_addr == 16'h0000) else $error("start address not zero");
    AST_RD_ANS:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
endmodule // sccr_monitor

bind sccr_top sccr_monitor sccr_monitor_inst (.clk(clk), .rstn(rstn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .sys_clk_en(sys_clk_en), .mcycle_en(mcycle_en),
    .mult_active(mult_active), .mult_x4_active(mult_x4_active), .slow_clock_mode(slow_clock_mode),
    .cpu_start_addr(cpu_start_addr));

/* sccr_osc_model.sv */
// Oscillator and supply source model
`timescale 1ns/10ps
module sccr_osc_model
(
    input wire logic clk,
    input wire logic pwr_cmd,
    input wire logic fail_cmd,
    output logic supply_ok = 1'b0,
    output logic osc_fail_det = 1'b0
);
    always_ff @(posedge clk)
    begin
        supply_ok <= pwr_cmd;
        osc_fail_det <= fail_cmd;
    end
endmodule // sccr_osc_model

/* tb_top.sv */
// Self-checking bench for the clock and reset control
`timescale 1ns/10ps
module tb_top;
    import sccr_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
    logic pwr = 1'b1, fail = 1'b0, stop = 1'b0, ring = 1'b0;
    logic [9:0] awa = 10'h000, ara = 10'h000;
    logic [31:0] wd = 32'h00000000, rd;
    logic [1:0] br, rr;
    logic awrdy, wrdy, bv, arrdy, rv, sup, ofd, ma, m4, slow, cpun;
    sccr_serial_t ser = '0;
    sccr_irq_t irq = '0;
    int mismatches = 0, checks_done = 0;
    always #25 clk = ~clk;
    sccr_osc_model sccr_osc_model_inst (.clk(clk), .pwr_cmd(pwr), .fail_cmd(fail), .supply_ok(sup),
        .osc_fail_det(ofd));
    sccr_top #(.LOCK_CYCLES(16)) sccr_top_inst (.clk(clk), .rstn(rstn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arrdy), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
        .serial(ser), .irq(irq), .supply_ok(sup), .osc_fail_det(ofd), .stop_mode(stop), .ring_osc_exit(ring),
        .sys_clk_en(), .mcycle_en(), .mult_active(ma), .mult_x4_active(m4), .slow_clock_mode(slow),
        .cpu_reset_n(cpun), .cpu_start_addr());
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] rsp);
        int n;
        @(posedge clk);
        awa <= {idx, 2'h0};
        wd <= {24'h000000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        for (n = 0; n < 64 && (awrdy & wrdy) !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        awv <= 1'b0;
        wv <= 1'b0;
        for (n = 0; n < 64 && bv !== 1'b1; n++) @(negedge clk);
        chk({n == 64, br}, {1'b0, rsp});
        if (n == 64) complete_run();
        @(posedge clk);
        brdy <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] rsp);
        int n;
        @(posedge clk);
        ara <= {idx, 2'h0};
        arv <= 1'b1;
        rrdy <= 1'b1;
        for (n = 0; n < 64 && arrdy !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        arv <= 1'b0;
        for (n = 0; n < 64 && rv !== 1'b1; n++) @(negedge clk);
        chk(rd, {24'h000000, exp});
        chk({n == 64, rr}, {1'b0, rsp});
        if (n == 64) complete_run();
        @(posedge clk);
        rrdy <= 1'b0;
    endtask
    // Waits for one of cpun, slow, ma, m4 to reach a level
    task automatic waitv(input int k, input logic v, input int lim);
        int n;
        logic [3:0] s;
        for (n = 0; n < lim; n++)
        begin
            @(negedge clk);
            s = {cpun, slow, ma, m4};
            if (s[k] === v)
                break;
        end
        chk(s[k], v);
        if (n == lim) complete_run();
        @(posedge clk);
    endtask
    task automatic t_reset;
        chk(cpun, 1'b0);
        waitv(3, 1'b1, 60);
        rdc(8'h01, 8'h80, 2'h0);
        rdc(8'h05, 8'h40, 2'h0);
        wr(8'h05, 8'h00, 2'h0);
        rdc(8'h05, 8'h00, 2'h0);
        wr(8'h40, 8'h00, 2'h2);
        rdc(8'h40, 8'h00, 2'h2);
        ring <= 1'b1;
        @(posedge clk);
        ring <= 1'b0;
        rdc(8'h02, 8'h04, 2'h0);
        repeat (16) @(posedge clk);
        rdc(8'h02, 8'h00, 2'h0);
        $display("reset test done");
    endtask
    task automatic t_status;
        irq <= 6'b111000;
        ser <= {3'h0, 3'h5, 3'h2, 6'h00};
        rdc(8'hC5, 8'hE9, 2'h0);
        rdc(8'hF7, 8'h01, 2'h0);
        wr(8'h01, 8'hC0, 2'h0);
        rdc(8'h01, 8'h80, 2'h0);
        irq <= '0;
        ser <= '0;
        $display("status test done");
    endtask
    task automatic t_slow;
        wr(8'h01, 8'h00, 2'h0);
        rdc(8'h01, 8'h80, 2'h0);
        wr(8'h01, 8'hE0, 2'h0);
        waitv(2, 1'b1, 20);
        wr(8'h01, 8'h20, 2'h0);
        rdc(8'h01, 8'hE0, 2'h0);
        irq <= 6'b000100;
        @(posedge clk);
        irq <= 6'b010110;
        @(posedge clk);
        irq <= 6'b000000;
        ser <= {3'h0, 9'h000, 3'h2};
        @(posedge clk);
        ser <= '0;
        rdc(8'h01, 8'hE0, 2'h0);
        irq <= 6'b000110;
        @(posedge clk);
        irq <= '0;
        rdc(8'h01, 8'hA0, 2'h0);
        waitv(2, 1'b0, 1100);
        wr(8'h01, 8'hE0, 2'h0);
        waitv(2, 1'b1, 20);
        ser <= {3'h2, 6'h00, 3'h2, 3'h0};
        @(posedge clk);
        ser <= '0;
        rdc(8'h01, 8'hA0, 2'h0);
        waitv(2, 1'b0, 1100);
        $display("slow test done");
    endtask
    task automatic t_mult(input logic [7:0] fac);
        wr(8'h01, 8'h80, 2'h0);
        wr(8'h01, 8'h80 | fac, 2'h0);
        wr(8'h01, 8'h90 | fac, 2'h0);
        rdc(8'h02, 8'h00, 2'h0);
        wr(8'h01, 8'h10 | fac, 2'h0);
        rdc(8'h01, 8'h90 | fac, 2'h0);
        repeat (16) @(posedge clk);
        rdc(8'h02, 8'h08, 2'h0);
        wr(8'h01, 8'h10 | fac, 2'h0);
        waitv(1, 1'b1, 10);
        chk(m4, fac[3]);
        wr(8'h01, 8'h90 | fac, 2'h0);
        waitv(1, 1'b0, 10);
        wr(8'h01, 8'h80 | fac, 2'h0);
        rdc(8'h02, 8'h00, 2'h0);
        $display("multiplier test done");
    endtask
    task automatic t_fail;
        wr(8'h04, 8'hAA, 2'h0);
        wr(8'h04, 8'h55, 2'h0);
        wr(8'h03, 8'h10, 2'h0);
        rdc(8'h03, 8'h10, 2'h0);
        wr(8'h03, 8'h00, 2'h0);
        rdc(8'h03, 8'h10, 2'h0);
        stop <= 1'b1;
        fail <= 1'b1;
        repeat (10) @(posedge clk);
        chk(cpun, 1'b1);
        stop <= 1'b0;
        waitv(3, 1'b0, 10);
        rdc(8'h03, 8'h30, 2'h0);
        fail <= 1'b0;
        waitv(3, 1'b1, 40);
        wr(8'h03, 8'h10, 2'h0);
        rdc(8'h03, 8'h10, 2'h0);
        pwr <= 1'b0;
        waitv(3, 1'b0, 10);
        pwr <= 1'b1;
        waitv(3, 1'b1, 40);
        rdc(8'h05, 8'h40, 2'h0);
        $display("fail test done");
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_status();
        t_slow();
        t_mult(8'h08);
        t_mult(8'h00);
        t_fail();
        complete_run();
    end
endmodule // tb_top
